// file: src/route_select_pkg.sv
// Constants shared by the serial audio route selector and its clock divider.
// Assumes one 20 MHz system clock and APB register access with 32-bit data.
`default_nettype none
package route_select_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FMT = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  // Control register fields
  localparam int CTRL_SRC_BIT = 0;
  localparam int CTRL_ROUTE_LSB = 1;
  localparam int CTRL_DIV_LSB = 4;
  localparam logic [31:0] FMT_RST = 32'h0000_0001;
  // Route select codes
  localparam logic [2:0] ROUTE_A_TO_IN_A = 3'h0;
  localparam logic [2:0] ROUTE_A_TO_IN_B = 3'h1;
  localparam logic [2:0] ROUTE_A_TO_IN_C = 3'h2;
  localparam logic [2:0] ROUTE_A_TO_ALL = 3'h3;
  localparam logic [2:0] ROUTE_B_TO_ALL = 3'h4;
  localparam logic [2:0] ROUTE_HEADER = 3'h7;
  // Master clock divider selects and ratios
  localparam logic [1:0] DIV_SEL_BY2 = 2'h0;
  localparam logic [1:0] DIV_SEL_RSVD = 2'h1;
  localparam logic [1:0] DIV_SEL_BY3 = 2'h2;
  localparam logic [1:0] DIV_SEL_BY4 = 2'h3;
  localparam logic [2:0] DIV_BY2 = 3'h2;
  localparam logic [2:0] DIV_BY3 = 3'h3;
  localparam logic [2:0] DIV_BY4 = 3'h4;
  // Port mode byte fields
  localparam int MB_DCK_LSB = 6;
  localparam int MB_PM_LSB = 4;
  localparam int MB_EDGE_BIT = 3;
  localparam logic [1:0] DCK_128 = 2'h0;
  localparam logic [1:0] DCK_48 = 2'h1;
  localparam logic [1:0] DCK_32 = 2'h2;
  localparam logic [1:0] DCK_64 = 2'h3;
  localparam logic [7:0] BCLK_128 = 8'h80;
  localparam logic [7:0] BCLK_48 = 8'h30;
  localparam logic [7:0] BCLK_32 = 8'h20;
  localparam logic [7:0] BCLK_64 = 8'h40;
  localparam logic [1:0] PM_SLAVE = 2'h0;
  localparam logic [1:0] PM_BURST = 2'h1;
  localparam logic [1:0] PM_NONBURST = 2'h2;
  localparam logic [2:0] DDF_RJ18 = 3'h1;
  localparam logic [2:0] DDF_RJ16 = 3'h2;
  localparam logic [2:0] DDF_LJ20 = 3'h3;
  localparam logic [2:0] DDF_I2S = 3'h4;
  localparam logic [1:0] WL_16 = 2'h0;
  localparam logic [1:0] WL_18 = 2'h1;
  localparam logic [1:0] WL_20 = 2'h2;
  // Status register fields
  localparam int ST_EDGE = 0;
  localparam int ST_JUST = 1;
  localparam int ST_WL_LSB = 2;
  localparam int ST_I2S = 4;
  localparam int ST_VALID = 5;
  localparam int ST_PM_LSB = 6;
  localparam int ST_BCLK_LSB = 8;
  // Synchroniser bit positions
  localparam int SY_OUT_A = 0;
  localparam int SY_OUT_B = 1;
  localparam int SY_HDR_LSB = 2;
  localparam int SY_CODEC_CLOCK_OUT = 5;
  localparam int SY_SCLK = 6;
  localparam int SY_LRCK = 7;
  localparam int SYNC_W = 8;
endpackage
`default_nettype wire

// file: src/mclk_div_if.sv
// Carrier between the route selector and its master clock divider.
// Assumes both ends run on the system clock.
`default_nettype none
interface mclk_div_if;
  logic [1:0] sel;
  logic src_edge;
  logic mclk;
  modport ctl (output sel, output src_edge, input mclk);
  modport div (input sel, input src_edge, output mclk);
endinterface
`default_nettype wire

// file: src/mclk_divider.sv
// Divides the sampled codec clock output down to the transmitter master clock.
// Assumes src_edge is a one-cycle pulse per rising edge of the codec clock.
`default_nettype none
module mclk_divider
  import route_select_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Divider link
  mclk_div_if.div dif
);
  typedef struct packed {
    logic [2:0] cnt;
    logic mclk;
  } div_state_t;

  div_state_t st_ff;
  div_state_t nxt_st;
  logic [2:0] len;

  always_comb begin
    nxt_st = st_ff;
    len = DIV_BY2;
    unique case (dif.sel)
      DIV_SEL_BY2: len = DIV_BY2;
      DIV_SEL_BY3: len = DIV_BY3;
      DIV_SEL_BY4: len = DIV_BY4;
      DIV_SEL_RSVD: len = 3'h0;
    endcase
    if (len == 3'h0) begin
      // Reserved select parks the clock low
      nxt_st = '0;
    end else if (dif.src_edge) begin
      nxt_st.cnt = (st_ff.cnt + 3'h1 >= len) ? 3'h0 : st_ff.cnt + 3'h1;
      nxt_st.mclk = (nxt_st.cnt < (len >> 1));
    end else if (st_ff.cnt >= len) begin
      // Select shrank under a running count
      nxt_st.cnt = 3'h0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dif.mclk = st_ff.mclk;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  a_div_reserved_low: assert property (
    (dif.sel == DIV_SEL_RSVD) |=> !st_ff.mclk && st_ff.cnt == 3'h0)
    else $error("divider runs on reserved select");
  a_div_by2_toggle: assert property (
    // A count left over from a wider select may not toggle on its first edge
    (dif.sel == DIV_SEL_BY2 && $past(dif.sel) == DIV_SEL_BY2 && dif.src_edge
    && st_ff.mclk == (st_ff.cnt == 3'h0))
    |=> st_ff.mclk != $past(st_ff.mclk))
    else $error("divide by two does not toggle per edge");
endmodule
`default_nettype wire

// file: src/serial_audio_route_select.sv
// Serial audio routing between a multichannel codec, a DSP header and a
// digital audio transmitter, with format straps and master clock division.
// Assumes APB register access on clk_sys_i; all audio pins are asynchronous.
//
// Functional notes
// - Transmitter data comes from codec output A when source select 0, else B.
// - Route 000 feeds codec input A from output A; inputs B, C zero.
// - Route 001 feeds codec input B from output A; inputs A, C zero.
// - Route 010 feeds codec input C from output A; inputs A, B zero.
// - Route 011 feeds all three codec inputs from codec output A.
// - Route 100 feeds all three codec inputs from codec output B.
// - Route 111 passes the three header data lines to the codec inputs.
// - I2S select is one exactly for data format code 4.
// - Edge select one for rising-edge formats, zero for falling-edge formats.
// - Right-justified 18-bit formats use justify 0 and word length 01.
// - Right-justified 16-bit formats use justify 0 and word length 00.
// - Left-justified 20-in 24-out formats use justify 1 and length 10.
// - I2S formats ignore justify and word length; they are driven zero.
// - Ratio codes 00, 01, 11 give 128, 48, 64 bit clocks; 01 is not valid in nonburst mode.
// - Ratio code 10 gives 32 bit clocks and forces 16-bit words.
// - Codec clock divided by 2, 3 or 4 per select; 01 reserved.
//
// Decided for this implementation: register access over APB and the placing of the registers.
`default_nettype none
module serial_audio_route_select
  import route_select_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // APB slave
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Codec and header serial pins
  input wire logic codec_serial_out_a_i,
  input wire logic codec_serial_out_b_i,
  input wire logic [2:0] dsp_header_i,
  input wire logic codec_clock_out_i,
  input wire logic codec_bit_clock_i,
  input wire logic codec_frame_clock_i,
  output logic codec_serial_in_a_o,
  output logic codec_serial_in_b_o,
  output logic codec_serial_in_c_o,
  // Transmitter pins
  output logic tx_serial_data_o,
  output logic tx_bit_clock_o,
  output logic tx_frame_clock_o,
  output logic tx_mclk_o,
  output logic tx_edge_select_o,
  output logic tx_justify_select_o,
  output logic tx_word_len_hi_o,
  output logic tx_word_len_lo_o,
  output logic tx_i2s_select_o
);
  typedef struct packed {
    logic edge_sel;
    logic just;
    logic [1:0] wl;
    logic i2s;
    logic valid;
    logic [1:0] pmode;
    logic [7:0] bclk;
  } fmt_t;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic clk_prev;
    logic src;
    logic [2:0] route;
    logic [1:0] div_sel;
    logic [7:0] mode;
    logic in_a;
    logic in_b;
    logic in_c;
    logic tx_data;
    logic sclk;
    logic lrck;
    logic mclk;
    fmt_t fmt;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  fmt_t fmt_now;
  logic [SYNC_W-1:0] pins;
  logic setup;
  logic wr_take;

  mclk_div_if dif ();

  mclk_divider u_div (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .dif(dif)
  );

  // Decode the codec port mode byte into transmitter straps
  function automatic fmt_t decode_fmt(input logic [7:0] mb);
    fmt_t f;
    logic [1:0] dck;
    logic [2:0] ddf;
    f = '0;
    dck = mb[MB_DCK_LSB +: 2];
    ddf = mb[2:0];
    f.pmode = mb[MB_PM_LSB +: 2];
    f.edge_sel = !mb[MB_EDGE_BIT];
    f.i2s = (ddf == DDF_I2S);
    f.just = (ddf == DDF_LJ20);
    unique case (ddf)
      DDF_RJ18: f.wl = WL_18;
      DDF_LJ20: f.wl = WL_20;
      default: f.wl = WL_16;
    endcase
    unique case (dck)
      DCK_128: f.bclk = BCLK_128;
      DCK_48: f.bclk = BCLK_48;
      DCK_64: f.bclk = BCLK_64;
      DCK_32: f.bclk = BCLK_32;
    endcase
    if (dck == DCK_32) begin
      // Short frames carry only 16-bit words
      f.wl = WL_16;
    end
    // Port mode 3 and nonburst at ratio 01 are undefined
    f.valid = (f.pmode != 2'h3) && (ddf <= DDF_I2S)
      && !(f.pmode == PM_NONBURST && dck == DCK_48)
      && (ddf != 3'h0 || dck == DCK_32);
    return f;
  endfunction

  // Straps of the reset mode byte, a constant so the reset branch loads no logic
  localparam fmt_t RST_FMT = '{edge_sel: 1'b1, just: 1'b0, wl: WL_18, i2s: 1'b0,
    valid: 1'b1, pmode: PM_SLAVE, bclk: BCLK_128};

  assign pins = {codec_frame_clock_i, codec_bit_clock_i, codec_clock_out_i,
                 dsp_header_i, codec_serial_out_b_i, codec_serial_out_a_i};
  assign fmt_now = decode_fmt(st_ff.mode);
  assign setup = psel_i && !penable_i;
  assign wr_take = psel_i && penable_i && st_ff.ready && pwrite_i && !st_ff.slverr;
  assign dif.sel = st_ff.div_sel;
  // Codec clock above half the system rate will lose edges here
  assign dif.src_edge = st_ff.s2[SY_CODEC_CLOCK_OUT] && !st_ff.clk_prev;

  always_comb begin
    nxt_st = st_ff;
    // Two flops on every pin before any logic reads it
    nxt_st.s1 = pins;
    nxt_st.s2 = st_ff.s1;
    nxt_st.clk_prev = st_ff.s2[SY_CODEC_CLOCK_OUT];
    nxt_st.sclk = st_ff.s2[SY_SCLK];
    nxt_st.lrck = st_ff.s2[SY_LRCK];
    nxt_st.mclk = dif.mclk;
    nxt_st.fmt = fmt_now;
    // Transmitter source
    nxt_st.tx_data = st_ff.src ? st_ff.s2[SY_OUT_B] : st_ff.s2[SY_OUT_A];
    // Codec input routing; unlisted codes stay silent
    nxt_st.in_a = 1'b0;
    nxt_st.in_b = 1'b0;
    nxt_st.in_c = 1'b0;
    unique case (st_ff.route)
      ROUTE_A_TO_IN_A: nxt_st.in_a = st_ff.s2[SY_OUT_A];
      ROUTE_A_TO_IN_B: nxt_st.in_b = st_ff.s2[SY_OUT_A];
      ROUTE_A_TO_IN_C: nxt_st.in_c = st_ff.s2[SY_OUT_A];
      ROUTE_A_TO_ALL: begin
        nxt_st.in_a = st_ff.s2[SY_OUT_A];
        nxt_st.in_b = st_ff.s2[SY_OUT_A];
        nxt_st.in_c = st_ff.s2[SY_OUT_A];
      end
      ROUTE_B_TO_ALL: begin
        nxt_st.in_a = st_ff.s2[SY_OUT_B];
        nxt_st.in_b = st_ff.s2[SY_OUT_B];
        nxt_st.in_c = st_ff.s2[SY_OUT_B];
      end
      ROUTE_HEADER: begin
        nxt_st.in_a = st_ff.s2[SY_HDR_LSB];
        nxt_st.in_b = st_ff.s2[SY_HDR_LSB+1];
        nxt_st.in_c = st_ff.s2[SY_HDR_LSB+2];
      end
      default: begin
      end
    endcase
    // APB: answer is prepared in setup so pready comes from a flop
    nxt_st.ready = setup;
    nxt_st.slverr = 1'b0;
    nxt_st.rdata = '0;
    if (setup) begin
      unique case (paddr_i)
        OFS_CTRL: begin
          nxt_st.rdata[CTRL_SRC_BIT] = st_ff.src;
          nxt_st.rdata[CTRL_ROUTE_LSB +: 3] = st_ff.route;
          nxt_st.rdata[CTRL_DIV_LSB +: 2] = st_ff.div_sel;
        end
        OFS_FMT: nxt_st.rdata[7:0] = st_ff.mode;
        OFS_STAT: begin
          nxt_st.rdata[ST_EDGE] = st_ff.fmt.edge_sel;
          nxt_st.rdata[ST_JUST] = st_ff.fmt.just;
          nxt_st.rdata[ST_WL_LSB +: 2] = st_ff.fmt.wl;
          nxt_st.rdata[ST_I2S] = st_ff.fmt.i2s;
          nxt_st.rdata[ST_VALID] = st_ff.fmt.valid;
          nxt_st.rdata[ST_PM_LSB +: 2] = st_ff.fmt.pmode;
          nxt_st.rdata[ST_BCLK_LSB +: 8] = st_ff.fmt.bclk;
        end
        default: nxt_st.slverr = 1'b1;
      endcase
      if (pwrite_i) begin
        nxt_st.rdata = '0;
      end
    end else if (psel_i && penable_i && !st_ff.ready) begin
      // Hold the answer until the access edge takes it
      nxt_st.ready = 1'b1;
      nxt_st.rdata = st_ff.rdata;
      nxt_st.slverr = st_ff.slverr;
    end
    // Writes land only at the access edge; status is read only
    if (wr_take && paddr_i == OFS_CTRL) begin
      nxt_st.src = pwdata_i[CTRL_SRC_BIT];
      nxt_st.route = pwdata_i[CTRL_ROUTE_LSB +: 3];
      nxt_st.div_sel = pwdata_i[CTRL_DIV_LSB +: 2];
    end
    if (wr_take && paddr_i == OFS_FMT) begin
      nxt_st.mode = pwdata_i[7:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
      st_ff.mode <= FMT_RST[7:0];
      st_ff.fmt <= RST_FMT;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata_o = st_ff.rdata;
  assign pready_o = st_ff.ready;
  assign pslverr_o = st_ff.slverr;
  assign codec_serial_in_a_o = st_ff.in_a;
  assign codec_serial_in_b_o = st_ff.in_b;
  assign codec_serial_in_c_o = st_ff.in_c;
  assign tx_serial_data_o = st_ff.tx_data;
  assign tx_bit_clock_o = st_ff.sclk;
  assign tx_frame_clock_o = st_ff.lrck;
  assign tx_mclk_o = st_ff.mclk;
  assign tx_edge_select_o = st_ff.fmt.edge_sel;
  assign tx_justify_select_o = st_ff.fmt.just;
  assign tx_word_len_hi_o = st_ff.fmt.wl[1];
  assign tx_word_len_lo_o = st_ff.fmt.wl[0];
  assign tx_i2s_select_o = st_ff.fmt.i2s;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  a_tx_source_a: assert property (
    !st_ff.src |=> tx_serial_data_o == $past(st_ff.s2[SY_OUT_A]))
    else $error("transmitter not fed from output A");
  a_tx_source_b: assert property (
    st_ff.src |=> tx_serial_data_o == $past(st_ff.s2[SY_OUT_B]))
    else $error("transmitter not fed from output B");
  a_route_a_in_a: assert property (
    (st_ff.route == ROUTE_A_TO_IN_A) |=> codec_serial_in_a_o == $past(st_ff.s2[SY_OUT_A])
    && !codec_serial_in_b_o && !codec_serial_in_c_o)
    else $error("route 0 wrong");
  a_route_a_in_b: assert property (
    (st_ff.route == ROUTE_A_TO_IN_B) |=> codec_serial_in_b_o == $past(st_ff.s2[SY_OUT_A])
    && !codec_serial_in_a_o && !codec_serial_in_c_o)
    else $error("route 1 wrong");
  a_route_a_in_c: assert property (
    (st_ff.route == ROUTE_A_TO_IN_C) |=> codec_serial_in_c_o == $past(st_ff.s2[SY_OUT_A])
    && !codec_serial_in_a_o && !codec_serial_in_b_o)
    else $error("route 2 wrong");
  a_route_a_all: assert property (
    (st_ff.route == ROUTE_A_TO_ALL) |=> {3{$past(st_ff.s2[SY_OUT_A])}}
    == {codec_serial_in_a_o, codec_serial_in_b_o, codec_serial_in_c_o})
    else $error("route 3 wrong");
  a_route_b_all: assert property (
    (st_ff.route == ROUTE_B_TO_ALL) |=> {3{$past(st_ff.s2[SY_OUT_B])}}
    == {codec_serial_in_a_o, codec_serial_in_b_o, codec_serial_in_c_o})
    else $error("route 4 wrong");
  a_route_header: assert property (
    (st_ff.route == ROUTE_HEADER) ##1 (st_ff.route == ROUTE_HEADER)
    |-> {codec_serial_in_c_o, codec_serial_in_b_o, codec_serial_in_a_o}
    == $past(st_ff.s2[SY_HDR_LSB +: 3]))
    else $error("header pass-through wrong");
  a_route_reserved: assert property (
    (st_ff.route inside {3'h5, 3'h6})
    |=> !codec_serial_in_a_o && !codec_serial_in_b_o && !codec_serial_in_c_o)
    else $error("reserved route not silent");
  a_fmt_i2s: assert property (
    (st_ff.mode[2:0] == DDF_I2S) [*2] |-> tx_i2s_select_o && !tx_justify_select_o
    && !tx_word_len_hi_o && !tx_word_len_lo_o)
    else $error("I2S straps wrong");
  a_fmt_edge: assert property (
    $stable(st_ff.mode) [*2] |-> tx_edge_select_o == !st_ff.mode[MB_EDGE_BIT])
    else $error("edge strap disagrees with mode byte");
  a_fmt_rj18: assert property (
    (st_ff.mode == 8'h01) [*2] |-> !tx_justify_select_o
    && {tx_word_len_hi_o, tx_word_len_lo_o} == WL_18)
    else $error("18-bit straps wrong");
  a_fmt_short_frame: assert property (
    (st_ff.mode[MB_DCK_LSB +: 2] == DCK_32) [*2]
    |-> {tx_word_len_hi_o, tx_word_len_lo_o} == WL_16)
    else $error("short frame not 16-bit");
  a_mclk_follow: assert property (
    (st_ff.div_sel == DIV_SEL_RSVD) [*3] |-> !tx_mclk_o)
    else $error("master clock runs on reserved select");
  // Straps lag the mode byte by one edge, hence the two-cycle antecedents
  a_fmt_rj16: assert property (
    (st_ff.mode[2:0] == DDF_RJ16) [*2] |-> !tx_justify_select_o
    && {tx_word_len_hi_o, tx_word_len_lo_o} == WL_16)
    else $error("16-bit straps wrong");
  a_fmt_lj20: assert property (
    (st_ff.mode[2:0] == DDF_LJ20 && st_ff.mode[MB_DCK_LSB +: 2] != DCK_32) [*2]
    |-> tx_justify_select_o && {tx_word_len_hi_o, tx_word_len_lo_o} == WL_20)
    else $error("left-justified straps wrong");
  a_fmt_lj_short: assert property (
    (st_ff.mode[2:0] == DDF_LJ20 && st_ff.mode[MB_DCK_LSB +: 2] == DCK_32) [*2]
    |-> tx_justify_select_o)
    else $error("short-frame left justify lost");
  // Bus answers one cycle after setup and holds for a single access cycle
  a_apb_answer: assert property (
    (psel_i && !penable_i) |=> pready_o)
    else $error("no answer after setup");
  a_apb_one_cycle: assert property (
    pready_o |=> !pready_o)
    else $error("ready held past the access cycle");
  a_apb_err_quiet: assert property (
    pslverr_o |-> pready_o && prdata_o == '0)
    else $error("error answer carries data");
  a_stat_no_write: assert property (
    (psel_i && penable_i && pwrite_i && pready_o && paddr_i == OFS_STAT)
    |=> $stable(st_ff.mode) && $stable(st_ff.route) && $stable(st_ff.src))
    else $error("status write changed a register");
endmodule
`default_nettype wire

// file: dv/codec_model.sv
// Behavioural codec and header side: serial outputs, clock output, bit and frame clocks.
// Assumes the bench supplies the data levels and the bit clock ratio code.
`default_nettype none
module codec_model #(
  parameter realtime CLK_HALF = 152.7,
  parameter realtime BCLK_HALF = 103.3
) (
  // Bench controls
  input wire logic [1:0] ratio_code_i,
  input wire logic data_a_i,
  input wire logic data_b_i,
  input wire logic [2:0] hdr_i,
  // Codec and header pins
  output logic codec_serial_out_a_o,
  output logic codec_serial_out_b_o,
  output logic [2:0] dsp_header_o,
  output logic codec_clock_out_o,
  output logic bit_clock_o,
  output logic frame_clock_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int bits_per_frame;
  int bit_cnt;
  // Odd half periods keep edges off the system clock edges most of the time
  always_comb begin
    case (ratio_code_i)
      2'h0: bits_per_frame = 128;
      2'h1: bits_per_frame = 48;
      2'h2: bits_per_frame = 32;
      default: bits_per_frame = 64;
    endcase
  end
  initial begin
    codec_clock_out_o = 1'b0;
    bit_clock_o = 1'b0;
    frame_clock_o = 1'b0;
    codec_serial_out_a_o = 1'b0;
    codec_serial_out_b_o = 1'b0;
    dsp_header_o = 3'h0;
    bit_cnt = 0;
  end
  always #(CLK_HALF) codec_clock_out_o = ~codec_clock_out_o;
  always #(BCLK_HALF) bit_clock_o = ~bit_clock_o;
  // Data moves on the falling bit clock edge, as a real codec launches it
  always @(negedge bit_clock_o) begin
    codec_serial_out_a_o <= data_a_i;
    codec_serial_out_b_o <= data_b_i;
    dsp_header_o <= hdr_i;
    bit_cnt = (bit_cnt + 1) % (bits_per_frame / 2);
    if (bit_cnt == 0) frame_clock_o <= ~frame_clock_o;
  end
endmodule
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the serial audio route selector.
// Assumes APB access with zero wait states is allowed but not relied on.
`default_nettype none
module tb
  import route_select_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic cs_a, cs_b, cclk, bclk, fclk;
  logic [2:0] hdr;
  logic in_a, in_b, in_c, tx_data, tx_bclk, tx_fclk, tx_mclk;
  logic st_edge, st_just, wl_hi, wl_lo, i2s;
  logic data_a = 1'b0;
  logic data_b = 1'b0;
  logic [2:0] hdr_v = 3'h0;
  logic [1:0] ratio = 2'h0;
  int n_fail = 0;
  int cmp_count = 0;
  logic [31:0] rd;
  logic err;

  always #25 clk_sys = ~clk_sys;

  codec_model i_codec (.ratio_code_i(ratio), .data_a_i(data_a), .data_b_i(data_b),
    .hdr_i(hdr_v), .codec_serial_out_a_o(cs_a), .codec_serial_out_b_o(cs_b),
    .dsp_header_o(hdr), .codec_clock_out_o(cclk), .bit_clock_o(bclk),
    .frame_clock_o(fclk));

  serial_audio_route_select i_dut (.clk_sys_i(clk_sys), .rstn_i(rstn), .paddr_i(paddr),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .codec_serial_out_a_i(cs_a), .codec_serial_out_b_i(cs_b), .dsp_header_i(hdr),
    .codec_clock_out_i(cclk), .codec_bit_clock_i(bclk), .codec_frame_clock_i(fclk),
    .codec_serial_in_a_o(in_a), .codec_serial_in_b_o(in_b), .codec_serial_in_c_o(in_c),
    .tx_serial_data_o(tx_data), .tx_bit_clock_o(tx_bclk), .tx_frame_clock_o(tx_fclk),
    .tx_mclk_o(tx_mclk), .tx_edge_select_o(st_edge), .tx_justify_select_o(st_just),
    .tx_word_len_hi_o(wl_hi), .tx_word_len_lo_o(wl_lo), .tx_i2s_select_o(i2s));

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                     output logic [31:0] rdat, output logic perr);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] exp_stat(input logic [7:0] b);
    logic [2:0] f;
    logic [1:0] wl;
    logic [7:0] bc;
    logic v;
    f = b[2:0];
    // Supported bytes: no mode 3, no nonburst at 48, code 0 only at ratio 32
    v = (b[5:4] != 2'h3) && (f <= 3'h4) && (f != 3'h0 || b[7:6] == 2'h2)
      && !(b[5:4] == 2'h2 && b[7:6] == 2'h1);
    wl = (b[7:6] == 2'h2) ? 2'h0 : (f == 3'h1) ? 2'h1 : (f == 3'h3) ? 2'h2 : 2'h0;
    case (b[7:6])
      2'h0: bc = 8'h80;
      2'h1: bc = 8'h30;
      2'h2: bc = 8'h20;
      default: bc = 8'h40;
    endcase
    return {16'h0, bc, b[5:4], v, f == 3'h4, wl, f == 3'h3, ~b[3]};
  endfunction

  function automatic logic [31:0] exp_route(input logic [2:0] r, input logic s,
                                            input logic a, input logic b, input logic [2:0] h);
    logic [2:0] v;
    case (r)
      3'h0: v = {a, 2'b00};
      3'h1: v = {1'b0, a, 1'b0};
      3'h2: v = {2'b00, a};
      3'h3: v = {3{a}};
      3'h4: v = {3{b}};
      3'h7: v = {h[0], h[1], h[2]};
      default: v = 3'h0;
    endcase
    return {28'h0, v, s ? b : a};
  endfunction

  function automatic logic [31:0] straps(input logic [31:0] e);
    return {27'h0, e[0], e[1], e[3], e[2], e[4]};
  endfunction

  logic [7:0] fmts[] = '{8'h01, 8'h41, 8'hc1, 8'h02, 8'h03, 8'h04, 8'h09, 8'h0a, 8'h0b,
    8'h0c, 8'h11, 8'h52, 8'hd3, 8'h14, 8'h19, 8'h1a, 8'h5b, 8'hdc, 8'h21, 8'he2, 8'h23,
    8'he4, 8'h29, 8'hea, 8'heb, 8'hec, 8'h80, 8'h82, 8'h84, 8'h8a, 8'h8c, 8'h93, 8'h9b,
    8'ha3, 8'hab, 8'h83, 8'h8b, 8'h61, 8'h35, 8'h9c};

  initial begin
    int ce, me, be, te, fe, tfe;
    logic pc, pm, pb, pt, pf, ptf;
    int dv;
    void'($urandom(32'h8ee29b1f));
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0, rd, err);
    chk(rd, 32'h0, "ctrl reset");
    apb(1'b0, OFS_FMT, 32'h0, rd, err);
    chk(rd, FMT_RST, "fmt reset");
    chk({st_edge, st_just, wl_hi, wl_lo, i2s}, straps(exp_stat(8'h01)), "reset straps");
    $display("test reset done");
    for (int r = 0; r < 8; r++) begin
      for (int s = 0; s < 2; s++) begin
        repeat (3) begin
          apb(1'b1, OFS_CTRL, {28'h0, 3'(r), 1'(s)}, rd, err);
          {data_a, data_b, hdr_v} <= 5'($urandom);
          repeat (12) @(posedge clk_sys);
          chk({in_a, in_b, in_c, tx_data}, exp_route(3'(r), 1'(s), data_a, data_b, hdr_v),
              "route");
        end
      end
    end
    $display("test routing done");
    foreach (fmts[i]) begin
      ratio <= fmts[i][7:6];
      apb(1'b1, OFS_FMT, {24'h0, fmts[i]}, rd, err);
      repeat (4) @(posedge clk_sys);
      apb(1'b0, OFS_STAT, 32'h0, rd, err);
      chk(rd, exp_stat(fmts[i]), "status");
      chk({st_edge, st_just, wl_hi, wl_lo, i2s}, straps(exp_stat(fmts[i])),
          "straps");
    end
    $display("test formats done");
    apb(1'b0, 8'h0c, 32'h0, rd, err);
    chk(rd, 32'h0, "unmapped read data");
    chk(32'(err), 32'h1, "unmapped read error");
    apb(1'b1, OFS_STAT, 32'hffff_ffff, rd, err);
    chk(err, 0, "status write error");
    apb(1'b0, OFS_STAT, 32'h0, rd, err);
    chk(rd, exp_stat(8'h9c), "status after write");
    $display("test register access done");
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, OFS_CTRL, {26'h0, 2'(d), 4'h0}, rd, err);
      repeat (20) @(posedge clk_sys);
      {ce, me, be, te, fe, tfe} = '0;
      {pc, pm, pb, pt, pf, ptf} = {cclk, tx_mclk, bclk, tx_bclk, fclk, tx_fclk};
      repeat (480) begin
        @(posedge clk_sys);
        ce += int'(cclk && !pc);
        me += int'(tx_mclk && !pm);
        be += int'(bclk && !pb);
        te += int'(tx_bclk && !pt);
        fe += int'(fclk && !pf);
        tfe += int'(tx_fclk && !ptf);
        {pc, pm, pb, pt, pf, ptf} = {cclk, tx_mclk, bclk, tx_bclk, fclk, tx_fclk};
      end
      dv = (d == 0) ? 2 : (d == 2) ? 3 : 4;
      dv = (d == 1) ? 0 : ce / dv;
      chk(32'(me > dv + 1 || me < dv - 1), 0, "mclk edge count");
      chk(32'(te > be + 1 || te < be - 1), 0, "bit clock forwarding");
      chk(32'(tfe > fe + 1 || tfe < fe - 1), 0, "frame clock forwarding");
    end
    $display("test clock division done");
    end_of_test();
  end

  initial begin
    #2_000_000;
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end
endmodule
`default_nettype wire
